//--- bench/sefp_checker.sv
// Checker: port-level properties of the fault polarity block
`timescale 1ns/1ns
module sefp_checker
  import sefp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic link_req,
  input wire logic irq,
  input wire logic serial_encoder_fault_routine,
  input wire logic [NAXES-1:0] encoder_fault_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read slot");
  a_pol_readback: assert property ((wr && addr == REG_POL) ##2
    (rd && addr == REG_POL) |=> rdata[3:0] == $past(wdata[3:0], 3))
    else $error("selection read back changed");
  a_routine_pulse: assert property (serial_encoder_fault_routine
    |=> !serial_encoder_fault_routine) else $error("routine not a pulse");
  a_routine_state: assert property (serial_encoder_fault_routine
    |-> ##[0:2] encoder_fault_state != 0) else $error("routine, no state");
  a_state_clear: assert property ((wr && addr == REG_STAT &&
    wdata[7:0] == 8'hFF) |-> ##[1:3] encoder_fault_state == 0)
    else $error("fault state not cleared");
  a_irq_masked: assert property ((wr && addr == REG_MASK &&
    wdata[7:0] == 8'h00) |-> ##[1:3] !irq) else $error("masked irq high");
  a_req_pulse: assert property (link_req |=> !link_req)
    else $error("request not a pulse");
  a_no_early: assert property (link_req
    |=> !serial_encoder_fault_routine [*8]) else $error("early fault");
endmodule // sefp_checker
bind sefp_top sefp_checker chk (.mclk, .resetn, .addr, .wdata, .wr, .rd,
  .rdata, .link_req, .irq, .serial_encoder_fault_routine,
  .encoder_fault_state);

//--- bench/sefp_enc_model.sv
// Encoder model: clocks out one frame per request on both axes
`timescale 1ns/1ns
module sefp_enc_model (
  input wire logic link_req,
  input wire logic [1:0] flags,
  input wire logic mute,
  input wire logic bad_crc,
  output logic link_clk,
  output logic [1:0] link_data
);
  logic [33:0] f [2];
  logic [27:0] d;
  logic [5:0] c;
  initial begin
    link_clk = 0;
    link_data = 2'h0;
    forever begin
      @(posedge link_req);
      for (int i = 0; i < 2; i++) begin
        // Position moves with the flags so a skipped capture shows
        d = {(i ? 26'h1555555 : 26'h2AAAAAA) ^ {24'h0, flags},
          flags};
        c = 6'h0;
        for (int k = 27; k >= 0; k--)
          c = {c[4:0], 1'b0} ^ ({6{c[5] ^ d[k]}} & 6'h03);
        f[i] = {d, c ^ {5'h0, bad_crc}};
      end
      // A mute encoder never starts, so the clock stays still
      for (int n = 34; n >= 0 && !mute; n--) begin
        link_data = n == 34 ? 2'h3 : {f[1][n], f[0][n]};
        #62 link_clk = 1;
        #63 link_clk = 0;
      end
      link_data = ~link_data;
    end
  end
endmodule // sefp_enc_model

//--- bench/tb_top.sv
// Testbench: polarity table, timeout, CRC and readback scenarios
`timescale 1ns/1ns
module tb_top
  import sefp_pkg::*;
;
  logic mclk = 0, resetn = 0, wr = 0, rd = 0, link_clk, link_req, irq;
  logic mute = 0, bad_crc = 0, serial_encoder_fault_routine;
  logic [1:0] flags = 2'h0, link_data, encoder_fault_state;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  int n_req = 0, n_routine = 0, n_rt = 0;
  always #5 mclk = ~mclk;
  sefp_top dut (.mclk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .link_clk,
    .link_data, .link_req, .irq, .serial_encoder_fault_routine,
    .encoder_fault_state);
  sefp_enc_model enc (.link_req, .flags, .mute, .bad_crc, .link_clk,
    .link_data);
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge mclk);
    wr <= 0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a; rd <= 1;
    @(posedge mclk);
    rd <= 0;
    @(negedge mclk);
    d = rdata;
  endtask
  // Polls busy; a hang here is cut by the cycle ceiling below
  task frame(input logic [3:0] pol, input logic [1:0] fl);
    int q, p;
    q = n_req;
    p = n_routine;
    wr_reg(REG_POL, {28'h0, pol});
    rd_reg(REG_POL, v);
    chk(v, {28'h0, pol});
    wr_reg(REG_STAT, 32'hFF);
    flags <= fl;
    wr_reg(REG_CTRL, 32'h1);
    // A second start while busy must not launch another read
    wr_reg(REG_CTRL, 32'h1);
    do rd_reg(REG_CTRL, v); while (v !== 32'h0);
    chk(n_req - q, 1);
    n_rt = n_routine - p;
    rd_reg(REG_STAT, v);
  endtask
  task t_table;
    logic [3:0] e0, e1;
    wr_reg(REG_MASK, 32'hFF);
    for (int s = 0; s < 4; s++)
      for (int f = 0; f < 4; f++) begin
        frame({~s[1:0], s[1:0]}, f[1:0]);
        e0 = {f[1] == s[1], f[0] == s[0], 2'h0};
        e1 = {f[1] != s[1], f[0] != s[0], 2'h0};
        chk(v, {24'h0, e1, e0});
        chk(encoder_fault_state, {|e1, |e0});
        chk(irq, |{e1, e0});
        chk(n_rt, |{e1, e0});
      end
    wr_reg(REG_MASK, 32'h0);
    $display("polarity table done");
  endtask
  task t_crc_pos;
    frame(4'h0, 2'h3);
    chk(v, 32'h0);
    rd_reg(REG_POS0, v);
    chk(v, 32'h2AAAAA9);
    frame(4'h0, 2'h2);
    chk(v, 32'h44);
    rd_reg(REG_POS0, v);
    chk(v, 32'h2AAAAA9);
    frame(4'h0, 2'h1);
    chk(v, 32'h88);
    rd_reg(REG_POS0, v);
    chk(v, 32'h2AAAAAB);
    rd_reg(REG_POS1, v);
    chk(v, 32'h1555554);
    bad_crc <= 1;
    frame(4'h0, 2'h3);
    chk(v, 32'h22);
    chk(n_rt, 1);
    rd_reg(REG_POS0, v);
    chk(v, 32'h2AAAAAB);
    bad_crc <= 0;
    $display("crc and position done");
  endtask
  task t_timeout;
    mute <= 1;
    frame(4'hF, 2'h0);
    chk(v, 32'h11);
    chk(n_rt, 1);
    mute <= 0;
    $display("timeout done");
  endtask
  task t_reset;
    wr_reg(REG_POL, 32'h0);
    wr_reg(REG_MASK, 32'hFF);
    @(posedge mclk);
    resetn <= 0;
    repeat (3) @(posedge mclk);
    resetn <= 1;
    rd_reg(REG_POL, v);
    chk(v, 32'hF);
    rd_reg(REG_STAT, v);
    chk(v, 32'h0);
    chk(encoder_fault_state, 2'h0);
    chk(irq, 1'b0);
    $display("mid-run reset done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (link_req === 1'b1) n_req++;
    if (serial_encoder_fault_routine === 1'b1) n_routine++;
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1;
    rd_reg(REG_POL, v);
    chk(v, 32'hF);
    t_table();
    t_crc_pos();
    t_timeout();
    t_reset();
    summarize();
  end
endmodule // tb_top

//--- verilog/sefp_axis.sv
// Per-axis receiver: frame shift, timeout, CRC and polarity evaluation
`timescale 1ns/1ns
module sefp_axis
  import sefp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  input wire logic tick,
  input wire logic sdata,
  input wire logic [1:0] fault_polarity_select,
  output logic done,
  output logic [3:0] events,
  output logic [POS_BITS-1:0] position
);
  typedef struct packed {
    sefp_state_e st;
    logic [11:0] tmo;
    logic [5:0] cnt;
    logic [FRAME_BITS-1:0] sh;
    logic done;
    logic [3:0] ev;
    logic [POS_BITS-1:0] pos;
  } sefp_ax_s;
  sefp_ax_s r, next_r;

  function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
    logic fb;
    fb = c[5] ^ b;
    crc_step = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
  endfunction

  always_comb begin
    logic [5:0] crc;
    logic err_raw;
    logic warn_raw;
    crc = 6'h00;
    next_r = r;
    next_r.done = 1'b0;
    err_raw = r.sh[CRC_BITS];
    warn_raw = r.sh[CRC_BITS+1];
    unique case (r.st)
      ST_IDLE: if (start) begin
        next_r.st = ST_WAIT;
        next_r.tmo = '0;
      end
      ST_WAIT: begin
        next_r.tmo = r.tmo + 12'h001;
        if (tick && sdata) begin
          next_r.st = ST_SHIFT;
          next_r.cnt = '0;
        end else if (r.tmo == 12'(TIMEOUT_CYC - 1)) begin
          next_r.ev = '0;
          next_r.ev[ST_TIMEOUT] = 1'b1; // Timeout after 30 us
          next_r.done = 1'b1;
          next_r.st = ST_IDLE;
        end
      end
      ST_SHIFT: if (tick) begin
        next_r.sh = {r.sh[FRAME_BITS-2:0], sdata};
        next_r.cnt = r.cnt + 6'h01;
        if (r.cnt == 6'(FRAME_BITS - 1)) next_r.st = ST_DONE;
      end
      ST_DONE: begin
        for (int i = FRAME_BITS - 1; i >= CRC_BITS; i--)
          crc = crc_step(crc, r.sh[i]);
        next_r.ev = '0;
        next_r.ev[ST_CRC] = (crc != r.sh[CRC_BITS-1:0]);
        // Bit 0 of select gives error polarity, bit 1 warning
        next_r.ev[ST_ERR] = fault_polarity_select[0] ? err_raw : ~err_raw;
        next_r.ev[ST_WARN] = fault_polarity_select[1] ? warn_raw : ~warn_raw;
        // Position trusted only from error flag and CRC, not warning
        if (!next_r.ev[ST_ERR] && !next_r.ev[ST_CRC])
          next_r.pos = r.sh[FRAME_BITS-1 -: POS_BITS];
        next_r.done = 1'b1;
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) r <= '0;
    else r <= next_r;
  end

  assign done = r.done;
  assign events = r.ev;
  assign position = r.pos;
endmodule // sefp_axis

//--- verilog/sefp_pkg.sv
// Package: constants for the serial encoder fault polarity block
package sefp_pkg;
  localparam int NAXES = 2;
  localparam logic [1:0] POL_RESET = 2'h3;
  // Register offsets
  localparam logic [3:0] REG_POL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_POS0 = 4'h3;
  localparam logic [3:0] REG_POS1 = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h5;
  localparam logic [3:0] REG_FAULT = 4'h6;
  // Status bit positions per axis (4 bits per axis)
  localparam int ST_TIMEOUT = 0;
  localparam int ST_CRC = 1;
  localparam int ST_ERR = 2;
  localparam int ST_WARN = 3;
  // Frame layout
  localparam int POS_BITS = 26;
  localparam int CRC_BITS = 6;
  localparam int FRAME_BITS = POS_BITS + 2 + CRC_BITS;
  localparam logic [5:0] CRC_POLY = 6'h03;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_US = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int CLK_DIV = 50;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DONE = 2'b11
  } sefp_state_e;
endpackage

//--- verilog/sefp_top.sv
// Top: register port, link clock sampling, fault status and interrupt
//
// Operation
// - Selects 0,1: warning active low
// - Selects 2,3: warning active high; reset 3
// - Asserted flag raises fault routine and state
// - Trust position from error flag and CRC only
// - Start bit absent 30 us: timeout
// - Six-bit CRC over data and flags
`timescale 1ns/1ns
module sefp_top
  import sefp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic link_clk,
  input wire logic [NAXES-1:0] link_data,
  output logic link_req,
  output logic irq,
  output logic serial_encoder_fault_routine,
  output logic [NAXES-1:0] encoder_fault_state
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2*NAXES-1:0] pol;
    logic [4*NAXES-1:0] stat;
    logic [4*NAXES-1:0] mask;
    logic [2:0] lc_s;
    logic [2*NAXES-1:0] ld_s;
    logic [NAXES-1:0] busy;
    logic req;
    logic [31:0] rdata;
    logic irq;
    logic routine;
    logic [NAXES-1:0] fault;
  } sefp_top_s;
  sefp_top_s r, next_r;

  logic tick;
  logic [NAXES-1:0] ax_done;
  logic [4*NAXES-1:0] ax_ev;
  logic [POS_BITS-1:0] ax_pos [NAXES];

  // Sample the link clock on rising edges; second stage feeds edge detect
  assign tick = r.lc_s[1] & ~r.lc_s[2];

  genvar g;
  generate
    for (g = 0; g < NAXES; g++) begin : gen_ax
      sefp_axis u_ax (
        .mclk(mclk),
        .resetn(resetn),
        .start(r.req),
        .tick(tick),
        .sdata(r.ld_s[NAXES+g]),
        .fault_polarity_select(r.pol[2*g +: 2]),
        .done(ax_done[g]),
        .events(ax_ev[4*g +: 4]),
        .position(ax_pos[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [4*NAXES-1:0] set;
    set = '0;
    next_r = r;
    next_r.lc_s = {r.lc_s[1:0], link_clk};
    next_r.ld_s = {r.ld_s[NAXES-1:0], link_data};
    next_r.req = 1'b0;
    for (int i = 0; i < NAXES; i++) begin
      if (ax_done[i]) begin
        set[4*i +: 4] = ax_ev[4*i +: 4];
        next_r.busy[i] = 1'b0;
      end
    end
    if (wr) begin
      unique case (addr)
        REG_POL: next_r.pol = wdata[2*NAXES-1:0];
        REG_STAT: next_r.stat = r.stat & ~wdata[4*NAXES-1:0];
        REG_MASK: next_r.mask = wdata[4*NAXES-1:0];
        REG_CTRL: if (wdata[0] && r.busy == '0) begin
          next_r.req = 1'b1;
          next_r.busy = '1;
        end
        default: ;
      endcase
    end
    // Set wins over a same-cycle write-one clear
    next_r.stat = next_r.stat | set;
    next_r.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        REG_POL: next_r.rdata = 32'(r.pol);
        REG_STAT: next_r.rdata = 32'(r.stat);
        REG_MASK: next_r.rdata = 32'(r.mask);
        REG_POS0: next_r.rdata = 32'(ax_pos[0]);
        REG_POS1: next_r.rdata = 32'(ax_pos[NAXES-1]);
        REG_CTRL: next_r.rdata = 32'(r.busy);
        REG_FAULT: next_r.rdata = 32'(r.fault);
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    for (int i = 0; i < NAXES; i++)
      next_r.fault[i] = |next_r.stat[4*i +: 4];
    next_r.routine = |set;
    next_r.irq = |(next_r.stat & r.mask);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.pol <= {NAXES{POL_RESET}};
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign link_req = r.req;
  assign irq = r.irq;
  assign serial_encoder_fault_routine = r.routine;
  assign encoder_fault_state = r.fault;
endmodule // sefp_top
